// ==== rtl/gpio_pkg.sv ====
package gpio_pkg;
	// ------------------------------------------------------------
	// geometry
	// ------------------------------------------------------------
	localparam int NUM_PORTS     = 2;
	localparam int PINS_PER_PORT = 16;
	localparam int NUM_PINS      = NUM_PORTS * PINS_PER_PORT;
	localparam int DATA_W        = 32;
	localparam int ADR_W         = 8;
	localparam int SEL_W         = DATA_W / 8;
	// ------------------------------------------------------------
	// pin_function_select layout
	// ------------------------------------------------------------
	localparam int FUNC_LSB   = 0;
	localparam int FUNC_W     = 6;
	localparam int NUM_FUNC   = 64;
	localparam int DIR_LSB    = 8;
	localparam int DIR_W      = 2;
	localparam int ANALOG_BIT = 10;
	localparam logic [FUNC_W-1:0] FUNC_GPIO = 6'h00;
	localparam logic [FUNC_W-1:0] FUNC_MAX  = 6'h3b;
	localparam logic [DIR_W-1:0]  DIR_INPUT     = 2'h0;
	localparam logic [DIR_W-1:0]  DIR_PULL_UP   = 2'h1;
	localparam logic [DIR_W-1:0]  DIR_PULL_DOWN = 2'h2;
	localparam logic [DIR_W-1:0]  DIR_OUTPUT    = 2'h3;
	localparam logic [DATA_W-1:0] MODE_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] MODE_MASK  = 32'h0000_073f;
	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [ADR_W-1:0] OFF_MODE_LAST = 8'h7c;
	localparam int               MODE_IDX_LSB  = 2;
	localparam int               MODE_IDX_MSB  = 6;
	localparam logic [ADR_W-1:0] OFF_P0_VALUE  = 8'h80;
	localparam logic [ADR_W-1:0] OFF_P0_SET    = 8'h84;
	localparam logic [ADR_W-1:0] OFF_P0_CLEAR  = 8'h88;
	localparam logic [ADR_W-1:0] PORT_STRIDE   = 8'h0c;
	localparam logic [ADR_W-1:0] OFF_HOLD      = 8'h98;
	localparam logic [ADR_W-1:0] OFF_FIXED     = 8'h9c;
	// ------------------------------------------------------------
	// fixed assignment control and pins
	// ------------------------------------------------------------
	localparam int FIX_W         = 3;
	localparam int FIX_RAM_BIT   = 0;
	localparam int FIX_APP_BIT   = 1;
	localparam int FIX_PROTO_BIT = 2;
	localparam logic [FIX_W-1:0] FIXED_RESET = 3'h6;
	localparam int PIN_RAM_CLK   = 0;
	localparam int PIN_RAM_CS    = 1;
	localparam int PIN_RAM_DQ0   = 2;
	localparam int RAM_DQ_W      = 4;
	localparam int PIN_APP_DIO   = 6;
	localparam int PIN_APP_CLK   = 7;
	localparam int PIN_PROTO_DIO = 8;
	localparam int PIN_PROTO_CLK = 9;
endpackage : gpio_pkg

// ==== rtl/pin_sync.sv ====
`timescale 1ns/10ps
module pin_sync #(
	parameter int WIDTH = 32
) (
	input  wire logic             clock_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// ------------------------------------------------------------
	// two flop synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule : pin_sync

// ==== rtl/pin_cell.sv ====
`timescale 1ns/10ps
module pin_cell
	import gpio_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              reset_n_in,
	input  wire logic              mode_we_in,
	input  wire logic [DATA_W-1:0] byte_mask_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              hold_in,
	input  wire logic              out_in,
	input  wire logic              oe_in,
	output logic      [DATA_W-1:0] mode_out,
	output logic                   pad_out_out,
	output logic                   pad_oe_out,
	output logic                   pull_up_out,
	output logic                   pull_down_out,
	output logic                   analog_out
);
	logic [DATA_W-1:0] wmask;
	logic [DIR_W-1:0]  dir;
	logic              ana;

	assign wmask = byte_mask_in & MODE_MASK;
	assign dir   = mode_out[DIR_LSB +: DIR_W];
	assign ana   = mode_out[ANALOG_BIT];

	// ------------------------------------------------------------
	// pin_function_select
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mode_out <= MODE_RESET;
		end else if (mode_we_in) begin
			mode_out <= (mode_out & ~wmask) | (wdata_in & wmask);
		end
	end

	// ------------------------------------------------------------
	// pad controls, frozen while held
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pad_out_out   <= 1'b0;
			pad_oe_out    <= 1'b0;
			pull_up_out   <= 1'b0;
			pull_down_out <= 1'b0;
			analog_out    <= 1'b0;
		end else if (!hold_in) begin
			pad_out_out   <= out_in;
			pad_oe_out    <= oe_in;
			pull_up_out   <= (dir == DIR_PULL_UP) && !ana && !oe_in;
			pull_down_out <= (dir == DIR_PULL_DOWN) && !ana && !oe_in;
			analog_out    <= ana;
		end
	end
endmodule : pin_cell

// ==== rtl/port_pin_mux_gpio.sv ====
`timescale 1ns/10ps
module port_pin_mux_gpio
	import gpio_pkg::*;
(
	input  wire logic                clock_in,
	input  wire logic                reset_n_in,
	input  wire logic                wb_cyc_in,
	input  wire logic                wb_stb_in,
	input  wire logic                wb_we_in,
	input  wire logic [ADR_W-1:0]    wb_adr_in,
	input  wire logic [SEL_W-1:0]    wb_sel_in,
	input  wire logic [DATA_W-1:0]   wb_dat_in,
	output logic      [DATA_W-1:0]   wb_dat_out,
	output logic                     wb_ack_out,
	input  wire logic [NUM_PINS-1:0] pad_in_in,
	output logic      [NUM_PINS-1:0] pad_out_out,
	output logic      [NUM_PINS-1:0] pad_oe_out,
	output logic      [NUM_PINS-1:0] pad_pull_up_out,
	output logic      [NUM_PINS-1:0] pad_pull_down_out,
	output logic      [NUM_PINS-1:0] pad_analog_out,
	output logic      [NUM_PINS-1:0] pin_level_out,
	input  wire logic [NUM_FUNC-1:0] periph_sig_in,
	output logic      [NUM_FUNC-1:0] periph_sig_out,
	input  wire logic                ram_clk_in,
	input  wire logic                ram_cs_n_in,
	input  wire logic [RAM_DQ_W-1:0] ram_dq_out_in,
	input  wire logic [RAM_DQ_W-1:0] ram_dq_oe_in,
	output logic      [RAM_DQ_W-1:0] ram_dq_out,
	input  wire logic                app_dbg_dio_in,
	input  wire logic                app_dbg_dio_oe_in,
	output logic                     app_dbg_dio_out,
	output logic                     app_dbg_clk_out,
	input  wire logic                proto_dbg_dio_in,
	input  wire logic                proto_dbg_dio_oe_in,
	output logic                     proto_dbg_dio_out,
	output logic                     proto_dbg_clk_out
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic                access;
	logic                wr_commit;
	logic                ack_q;
	logic [DATA_W-1:0]   rd_d;
	logic [DATA_W-1:0]   rd_q;
	logic [DATA_W-1:0]   byte_mask;
	logic [NUM_PINS-1:0] out_q;
	logic [NUM_PINS-1:0] hold_q;
	logic [FIX_W-1:0]    fixed_q;
	logic [NUM_PINS-1:0] pad_sync;
	logic [NUM_PINS-1:0] pin_level_q;
	logic [NUM_PINS-1:0] analog_sel;
	logic [NUM_PINS-1:0] fix_own;
	logic [NUM_PINS-1:0] fix_out;
	logic [NUM_PINS-1:0] fix_oe;
	logic [NUM_PINS-1:0] live_out;
	logic [NUM_PINS-1:0] live_oe;
	logic [NUM_PINS-1:0] mode_we;
	logic [NUM_FUNC-1:0] periph_in_d;
	logic [DATA_W-1:0]   mode_q [NUM_PINS];

	function automatic logic [ADR_W-1:0] port_adr(input int p, input logic [ADR_W-1:0] base);
		return base + ADR_W'(p) * PORT_STRIDE;
	endfunction : port_adr

	// ------------------------------------------------------------
	// wishbone slave
	// ------------------------------------------------------------
	assign access    = wb_cyc_in && wb_stb_in && !ack_q;
	assign wr_commit = wb_cyc_in && wb_stb_in && wb_we_in && ack_q;
	assign byte_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= access;
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rd_q <= '0;
		end else if (access) begin
			rd_q <= wb_we_in ? '0 : rd_d;
		end else begin
			rd_q <= '0;
		end
	end

	assign wb_ack_out = ack_q;
	assign wb_dat_out = rd_q;

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	always_comb begin
		rd_d = '0;
		if (wb_adr_in <= OFF_MODE_LAST) begin
			rd_d = mode_q[wb_adr_in[MODE_IDX_MSB:MODE_IDX_LSB]];
		end else if (wb_adr_in == OFF_HOLD) begin
			rd_d = hold_q;
		end else if (wb_adr_in == OFF_FIXED) begin
			rd_d[FIX_W-1:0] = fixed_q;
		end
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (wb_adr_in == port_adr(p, OFF_P0_VALUE)) begin
				rd_d[PINS_PER_PORT-1:0] = pin_level_q[p*PINS_PER_PORT +: PINS_PER_PORT];
			end
		end
	end

	// ------------------------------------------------------------
	// port_pin_value, port_bit_set, port_bit_clear
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			out_q <= '0;
		end else if (wr_commit) begin
			for (int p = 0; p < NUM_PORTS; p++) begin
				if (wb_adr_in == port_adr(p, OFF_P0_VALUE)) begin
					out_q[p*PINS_PER_PORT +: PINS_PER_PORT] <=
						(out_q[p*PINS_PER_PORT +: PINS_PER_PORT] & ~byte_mask[PINS_PER_PORT-1:0]) |
						(wb_dat_in[PINS_PER_PORT-1:0] & byte_mask[PINS_PER_PORT-1:0]);
				end else if (wb_adr_in == port_adr(p, OFF_P0_SET)) begin
					out_q[p*PINS_PER_PORT +: PINS_PER_PORT] <=
						out_q[p*PINS_PER_PORT +: PINS_PER_PORT] |
						(wb_dat_in[PINS_PER_PORT-1:0] & byte_mask[PINS_PER_PORT-1:0]);
				end else if (wb_adr_in == port_adr(p, OFF_P0_CLEAR)) begin
					out_q[p*PINS_PER_PORT +: PINS_PER_PORT] <=
						out_q[p*PINS_PER_PORT +: PINS_PER_PORT] &
						~(wb_dat_in[PINS_PER_PORT-1:0] & byte_mask[PINS_PER_PORT-1:0]);
				end
			end
		end
	end

	// ------------------------------------------------------------
	// pad_hold_control and fixed assignment control
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hold_q <= '0;
		end else if (wr_commit && wb_adr_in == OFF_HOLD) begin
			hold_q <= (hold_q & ~byte_mask) | (wb_dat_in & byte_mask);
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			fixed_q <= FIXED_RESET;
		end else if (wr_commit && wb_adr_in == OFF_FIXED) begin
			fixed_q <= (fixed_q & ~byte_mask[FIX_W-1:0]) | (wb_dat_in[FIX_W-1:0] & byte_mask[FIX_W-1:0]);
		end
	end

	// ------------------------------------------------------------
	// pin input synchroniser and level view
	// ------------------------------------------------------------
	pin_sync #(
		.WIDTH (NUM_PINS)
	) u_pad_sync (
		.clock_in   (clock_in),
		.reset_n_in (reset_n_in),
		.async_in   (pad_in_in),
		.sync_out   (pad_sync)
	);

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			analog_sel[i] = mode_q[i][ANALOG_BIT];
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			pin_level_q <= '0;
		end else begin
			pin_level_q <= pad_sync & ~analog_sel;
		end
	end

	assign pin_level_out = pin_level_q;

	// ------------------------------------------------------------
	// fixed assignments
	// ------------------------------------------------------------
	always_comb begin
		fix_own = '0;
		fix_out = '0;
		fix_oe  = '0;
		if (fixed_q[FIX_RAM_BIT]) begin
			fix_own[PIN_RAM_CLK]              = 1'b1;
			fix_out[PIN_RAM_CLK]              = ram_clk_in;
			fix_oe[PIN_RAM_CLK]               = 1'b1;
			fix_own[PIN_RAM_CS]               = 1'b1;
			fix_out[PIN_RAM_CS]               = ram_cs_n_in;
			fix_oe[PIN_RAM_CS]                = 1'b1;
			fix_own[PIN_RAM_DQ0 +: RAM_DQ_W]  = '1;
			fix_out[PIN_RAM_DQ0 +: RAM_DQ_W]  = ram_dq_out_in;
			fix_oe[PIN_RAM_DQ0 +: RAM_DQ_W]   = ram_dq_oe_in;
		end
		if (fixed_q[FIX_APP_BIT]) begin
			fix_own[PIN_APP_DIO] = 1'b1;
			fix_out[PIN_APP_DIO] = app_dbg_dio_in;
			fix_oe[PIN_APP_DIO]  = app_dbg_dio_oe_in;
			fix_own[PIN_APP_CLK] = 1'b1;
		end
		if (fixed_q[FIX_PROTO_BIT]) begin
			fix_own[PIN_PROTO_DIO] = 1'b1;
			fix_out[PIN_PROTO_DIO] = proto_dbg_dio_in;
			fix_oe[PIN_PROTO_DIO]  = proto_dbg_dio_oe_in;
			fix_own[PIN_PROTO_CLK] = 1'b1;
		end
	end

	// ------------------------------------------------------------
	// programmable_pin_routing, output side
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			live_out[i] = 1'b0;
			live_oe[i]  = 1'b0;
			if (fix_own[i]) begin
				live_out[i] = fix_out[i];
				live_oe[i]  = fix_oe[i];
			end else if (!mode_q[i][ANALOG_BIT] && mode_q[i][DIR_LSB +: DIR_W] == DIR_OUTPUT) begin
				live_oe[i] = 1'b1;
				if (mode_q[i][FUNC_LSB +: FUNC_W] == FUNC_GPIO) begin
					live_out[i] = out_q[i];
				end else if (mode_q[i][FUNC_LSB +: FUNC_W] <= FUNC_MAX) begin
					live_out[i] = periph_sig_in[mode_q[i][FUNC_LSB +: FUNC_W]];
				end
			end
		end
	end

	// ------------------------------------------------------------
	// programmable_pin_routing, input side
	// ------------------------------------------------------------
	always_comb begin
		periph_in_d = '0;
		for (int i = NUM_PINS - 1; i >= 0; i--) begin
			if (!fix_own[i] && !mode_q[i][ANALOG_BIT] &&
				mode_q[i][DIR_LSB +: DIR_W] != DIR_OUTPUT &&
				mode_q[i][FUNC_LSB +: FUNC_W] != FUNC_GPIO &&
				mode_q[i][FUNC_LSB +: FUNC_W] <= FUNC_MAX) begin
				periph_in_d[mode_q[i][FUNC_LSB +: FUNC_W]] = pad_sync[i];
			end
		end
	end

	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			periph_sig_out <= '0;
		end else begin
			periph_sig_out <= periph_in_d;
		end
	end

	// ------------------------------------------------------------
	// fixed function input views
	// ------------------------------------------------------------
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ram_dq_out        <= '0;
			app_dbg_dio_out   <= 1'b0;
			app_dbg_clk_out   <= 1'b0;
			proto_dbg_dio_out <= 1'b0;
			proto_dbg_clk_out <= 1'b0;
		end else begin
			ram_dq_out        <= fixed_q[FIX_RAM_BIT] ? pad_sync[PIN_RAM_DQ0 +: RAM_DQ_W] : '0;
			app_dbg_dio_out   <= fixed_q[FIX_APP_BIT] & pad_sync[PIN_APP_DIO];
			app_dbg_clk_out   <= fixed_q[FIX_APP_BIT] & pad_sync[PIN_APP_CLK];
			proto_dbg_dio_out <= fixed_q[FIX_PROTO_BIT] & pad_sync[PIN_PROTO_DIO];
			proto_dbg_clk_out <= fixed_q[FIX_PROTO_BIT] & pad_sync[PIN_PROTO_CLK];
		end
	end

	// ------------------------------------------------------------
	// per pin cells
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			mode_we[i] = wr_commit && wb_adr_in <= OFF_MODE_LAST &&
				wb_adr_in[MODE_IDX_MSB:MODE_IDX_LSB] == i[MODE_IDX_MSB-MODE_IDX_LSB:0];
		end
	end

	for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
		pin_cell u_cell (
			.clock_in      (clock_in),
			.reset_n_in    (reset_n_in),
			.mode_we_in    (mode_we[g]),
			.byte_mask_in  (byte_mask),
			.wdata_in      (wb_dat_in),
			.hold_in       (hold_q[g]),
			.out_in        (live_out[g]),
			.oe_in         (live_oe[g]),
			.mode_out      (mode_q[g]),
			.pad_out_out   (pad_out_out[g]),
			.pad_oe_out    (pad_oe_out[g]),
			.pull_up_out   (pad_pull_up_out[g]),
			.pull_down_out (pad_pull_down_out[g]),
			.analog_out    (pad_analog_out[g])
		);
	end
endmodule : port_pin_mux_gpio

// ==== dv/pad_model.sv ====
`timescale 1ns/10ps
module pad_model
	import gpio_pkg::*;
(
	input  wire logic                clock_in,
	input  wire logic                reset_n_in,
	input  wire logic [NUM_PINS-1:0] pad_out_in,
	input  wire logic [NUM_PINS-1:0] pad_oe_in,
	input  wire logic [NUM_PINS-1:0] pull_up_in,
	input  wire logic [NUM_PINS-1:0] pull_down_in,
	input  wire logic [NUM_PINS-1:0] ext_val_in,
	input  wire logic [NUM_PINS-1:0] ext_en_in,
	output logic      [NUM_PINS-1:0] level_out
);
	// ------------------------------------------------------------
	// wire level: device drive, then outside drive, then pulls
	// ------------------------------------------------------------
	logic float_q;
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) float_q <= 1'b0;
		else float_q <= ~float_q;
	end
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (pad_oe_in[i]) level_out[i] = pad_out_in[i];
			else if (ext_en_in[i]) level_out[i] = ext_val_in[i];
			else if (pull_up_in[i]) level_out[i] = 1'b1;
			else if (pull_down_in[i]) level_out[i] = 1'b0;
			else level_out[i] = float_q;
		end
	end
endmodule : pad_model

// ==== dv/port_pin_mux_gpio_checker.sv ====
`timescale 1ns/10ps
module port_pin_mux_gpio_checker
	import gpio_pkg::*;
(
	input wire logic                clock_in,
	input wire logic                reset_n_in,
	input wire logic                wb_cyc_in,
	input wire logic                wb_stb_in,
	input wire logic                wb_we_in,
	input wire logic [ADR_W-1:0]    wb_adr_in,
	input wire logic [SEL_W-1:0]    wb_sel_in,
	input wire logic [DATA_W-1:0]   wb_dat_in,
	input wire logic [DATA_W-1:0]   wb_dat_out,
	input wire logic                wb_ack_out,
	input wire logic [NUM_PINS-1:0] pad_in_in,
	input wire logic [NUM_PINS-1:0] pad_out_out,
	input wire logic [NUM_PINS-1:0] pad_oe_out,
	input wire logic [NUM_PINS-1:0] pad_pull_up_out,
	input wire logic [NUM_PINS-1:0] pad_pull_down_out,
	input wire logic [NUM_PINS-1:0] pad_analog_out,
	input wire logic [NUM_PINS-1:0] pin_level_out,
	input wire logic                app_dbg_clk_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in);
	logic [2:0] up_q;
	logic       set_w;
	logic       clr_w;
	assign set_w = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & (wb_sel_in[1:0] == 2'h3) & (wb_adr_in == OFF_P0_SET);
	assign clr_w = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out & (wb_sel_in[1:0] == 2'h3) & (wb_adr_in == OFF_P0_CLEAR);
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) up_q <= 3'h0;
		else if (up_q != 3'h7) up_q <= up_q + 3'h1;
	end
	a_ack_one_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
	a_ack_one_wait: assert property ((wb_cyc_in && wb_stb_in && !wb_ack_out) |=> wb_ack_out)
		else $error("ack not one cycle after request");
	a_idle_data_zero: assert property (!wb_ack_out |-> wb_dat_out == '0) else $error("read data outside ack");
	a_pull_off_drive: assert property (((pad_oe_out | pad_analog_out)
		& (pad_pull_up_out | pad_pull_down_out)) == '0) else $error("pull on while driving or analog");
	a_reset_no_drive: assert property ($rose(reset_n_in) |-> ((pad_oe_out & ~32'h0000_0140) == 32'h0)[*3])
		else $error("pin drives after reset");
	a_set_bits_high: assert property (set_w |-> ##2 (((pad_out_out[15:10] | ~pad_oe_out[15:10])
		& $past(wb_dat_in[15:10], 2)) == $past(wb_dat_in[15:10], 2))) else $error("set bit not high");
	a_clear_bits_low: assert property (clr_w |-> ##2 ((pad_out_out[15:10] & pad_oe_out[15:10]
		& $past(wb_dat_in[15:10], 2)) == 6'h00)) else $error("clear bit not low");
	a_app_clk_path: assert property (up_q == 3'h7 |-> app_dbg_clk_out == $past(pad_in_in[PIN_APP_CLK], 3))
		else $error("debug clock pin not forwarded");
	a_level_tracks_pad: assert property (up_q == 3'h7 |-> (($past(pin_level_out, 2) ^ $past(pad_in_in, 5))
		& ~(pad_analog_out | $past(pad_analog_out, 1) | $past(pad_analog_out, 2) | $past(pad_analog_out, 3)
		| $past(pad_analog_out, 4) | $past(pad_analog_out, 5))) == '0) else $error("pin level wrong");
	a_analog_reads_zero: assert property (($past(pin_level_out, 1) & pad_analog_out & $past(pad_analog_out, 1)
		& $past(pad_analog_out, 2)) == '0) else $error("analog pin level not zero");
	c_set_write: cover property (set_w);
	c_clear_write: cover property (clr_w);
	c_analog_pin: cover property (pad_analog_out != '0);
endmodule : port_pin_mux_gpio_checker
bind port_pin_mux_gpio port_pin_mux_gpio_checker i_chk (.clock_in(clock_in), .reset_n_in(reset_n_in),
	.wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
	.wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.pad_in_in(pad_in_in), .pad_out_out(pad_out_out), .pad_oe_out(pad_oe_out),
	.pad_pull_up_out(pad_pull_up_out), .pad_pull_down_out(pad_pull_down_out),
	.pad_analog_out(pad_analog_out), .pin_level_out(pin_level_out), .app_dbg_clk_out(app_dbg_clk_out));

// ==== dv/tb_port_pin_mux_gpio.sv ====
`timescale 1ns/10ps
module tb_port_pin_mux_gpio
	import gpio_pkg::*;
;
	localparam logic [ADR_W-1:0] P1_VAL = OFF_P0_VALUE + PORT_STRIDE;
	localparam logic [ADR_W-1:0] P1_CLR = OFF_P0_CLEAR + PORT_STRIDE;
	logic clock_in, reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
	logic [ADR_W-1:0]    wb_adr_in;
	logic [SEL_W-1:0]    wb_sel_in;
	logic [DATA_W-1:0]   wb_dat_in, wb_dat_out;
	logic [NUM_PINS-1:0] pad_in_in, pad_out_out, pad_oe_out, pad_pull_up_out, pad_pull_down_out;
	logic [NUM_PINS-1:0] pad_analog_out, pin_level_out, ext_val, ext_en;
	logic [NUM_FUNC-1:0] periph_sig_in, periph_sig_out;
	logic                ram_clk_in, ram_cs_n_in;
	logic [RAM_DQ_W-1:0] ram_dq_out_in, ram_dq_oe_in, ram_dq_out;
	logic app_dbg_dio_in, app_dbg_dio_oe_in, app_dbg_dio_out, app_dbg_clk_out;
	logic proto_dbg_dio_in, proto_dbg_dio_oe_in, proto_dbg_dio_out, proto_dbg_clk_out;
	int   error_cnt, samples_checked;
	port_pin_mux_gpio i_dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
		.wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
		.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .pad_in_in(pad_in_in),
		.pad_out_out(pad_out_out), .pad_oe_out(pad_oe_out), .pad_pull_up_out(pad_pull_up_out),
		.pad_pull_down_out(pad_pull_down_out), .pad_analog_out(pad_analog_out), .pin_level_out(pin_level_out),
		.periph_sig_in(periph_sig_in), .periph_sig_out(periph_sig_out), .ram_clk_in(ram_clk_in),
		.ram_cs_n_in(ram_cs_n_in), .ram_dq_out_in(ram_dq_out_in), .ram_dq_oe_in(ram_dq_oe_in),
		.ram_dq_out(ram_dq_out), .app_dbg_dio_in(app_dbg_dio_in), .app_dbg_dio_oe_in(app_dbg_dio_oe_in),
		.app_dbg_dio_out(app_dbg_dio_out), .app_dbg_clk_out(app_dbg_clk_out), .proto_dbg_dio_in(proto_dbg_dio_in),
		.proto_dbg_dio_oe_in(proto_dbg_dio_oe_in), .proto_dbg_dio_out(proto_dbg_dio_out),
		.proto_dbg_clk_out(proto_dbg_clk_out));
	pad_model i_pad (.clock_in(clock_in), .reset_n_in(reset_n_in), .pad_out_in(pad_out_out), .pad_oe_in(pad_oe_out),
		.pull_up_in(pad_pull_up_out), .pull_down_in(pad_pull_down_out), .ext_val_in(ext_val),
		.ext_en_in(ext_en), .level_out(pad_in_in));
	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic summarize();
		if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	task automatic wb(input logic we, input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d,
		output logic [DATA_W-1:0] q);
		int n;
		n = 0;
		@(posedge clock_in);
		wb_cyc_in <= 1'b1;
		wb_stb_in <= 1'b1;
		wb_we_in <= we;
		wb_adr_in <= a;
		wb_dat_in <= d;
		do begin
			@(posedge clock_in);
			n++;
		end while (wb_ack_out !== 1'b1 && n < 16);
		if (n >= 16) begin
			error_cnt++;
			summarize();
		end
		q = wb_dat_out;
		wb_cyc_in <= 1'b0;
		wb_stb_in <= 1'b0;
		wb_we_in <= 1'b0;
	endtask : wb
	task automatic wr(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] q;
		wb(1'b1, a, d, q);
	endtask : wr
	task automatic chk_rd(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] e);
		logic [DATA_W-1:0] q;
		wb(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), 64'(e), 64'(q));
	endtask : chk_rd
	task automatic cfg(input int pin, input logic [DIR_W-1:0] dir, input logic [FUNC_W-1:0] fn, input logic ana);
		wr(8'(pin * 4), (32'(ana) << ANALOG_BIT) | (32'(dir) << DIR_LSB) | 32'(fn));
	endtask : cfg
	task automatic settle();
		repeat (6) @(posedge clock_in);
	endtask : settle
	// ------------------------------------------------------------
	// clock, timeout, sequence
	// ------------------------------------------------------------
	initial begin
		clock_in = 1'b0;
		forever #20 clock_in = ~clock_in;
	end
	initial begin
		repeat (20000) @(posedge clock_in);
		error_cnt++;
		summarize();
	end
	initial begin
		{reset_n_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_adr_in, wb_dat_in, ext_val} = '0;
		{periph_sig_in, ram_clk_in, ram_dq_out_in, ram_dq_oe_in, app_dbg_dio_in, app_dbg_dio_oe_in} = '0;
		{proto_dbg_dio_in, proto_dbg_dio_oe_in, error_cnt, samples_checked} = '0;
		wb_sel_in = 4'hf;
		ram_cs_n_in = 1'b1;
		ext_en = '1;
		repeat (5) @(posedge clock_in);
		reset_n_in <= 1'b1;
		chk_rd(8'h00, MODE_RESET);
		chk_rd(OFF_MODE_LAST, MODE_RESET);
		chk_rd(OFF_FIXED, 32'(FIXED_RESET));
		chk_rd(8'hfc, 32'h0);
		chk("oe", 64'h0, 64'(pad_oe_out));
		wr(8'h28, 32'hffff_ffff);
		chk_rd(8'h28, MODE_MASK);
		for (int i = 10; i < 16; i++) cfg(i, DIR_OUTPUT, FUNC_GPIO, 1'b0);
		wr(OFF_P0_VALUE, 32'h5400);
		settle();
		chk("p0 out", 64'h5400, 64'(pad_out_out & 32'hfc00));
		chk("p0 oe", 64'hfc00, 64'(pad_oe_out & 32'hfc00));
		chk_rd(OFF_P0_VALUE, 32'h5400);
		wr(OFF_P0_SET, 32'h0800);
		wr(OFF_P0_CLEAR, 32'h4400);
		settle();
		chk("p0 set clr", 64'h1800, 64'(pad_out_out & 32'hfc00));
		chk_rd(OFF_P0_SET, 32'h0);
		ext_val <= 32'h00a7_0000;
		settle();
		chk_rd(P1_VAL, 32'h00a7);
		ext_en[16] <= 1'b0;
		cfg(16, DIR_PULL_DOWN, FUNC_GPIO, 1'b0);
		settle();
		chk("pd16", 64'h1, 64'(pad_pull_down_out[16]));
		chk_rd(P1_VAL, 32'h00a6);
		cfg(16, DIR_OUTPUT, FUNC_GPIO, 1'b0);
		cfg(17, DIR_PULL_UP, FUNC_GPIO, 1'b1);
		settle();
		chk("pulls", 64'h0, 64'({pad_pull_down_out[16], pad_pull_up_out[17]}));
		chk("ana17", 64'h1, 64'(pad_analog_out[17]));
		chk_rd(P1_VAL, 32'h00a4);
		for (int c = 1; c <= int'(FUNC_MAX); c++) begin
			cfg(18, DIR_OUTPUT, 6'(c), 1'b0);
			periph_sig_in <= 64'h1 << c;
			settle();
			chk($sformatf("route %h", c), 64'h1, 64'(pad_out_out[18]));
		end
		periph_sig_in <= '1;
		cfg(18, DIR_OUTPUT, 6'h3c, 1'b0);
		settle();
		chk("route none", 64'h0, 64'(pad_out_out[18]));
		cfg(19, DIR_INPUT, 6'h07, 1'b0);
		cfg(20, DIR_INPUT, 6'h07, 1'b0);
		ext_val[19] <= 1'b1;
		settle();
		chk("in pick hi", 64'h1, 64'(periph_sig_out[7]));
		ext_val[19] <= 1'b0;
		ext_val[20] <= 1'b1;
		settle();
		chk("in pick lo", 64'h0, 64'(periph_sig_out[7]));
		cfg(21, DIR_OUTPUT, FUNC_GPIO, 1'b0);
		wr(P1_VAL, 32'h0020);
		wr(OFF_HOLD, 32'h0020_0000);
		chk_rd(OFF_HOLD, 32'h0020_0000);
		wr(P1_CLR, 32'h0020);
		settle();
		chk("held", 64'h1, 64'(pad_out_out[21]));
		wr(OFF_HOLD, 32'h0);
		settle();
		chk("released", 64'h0, 64'(pad_out_out[21]));
		ram_clk_in <= 1'b1;
		ram_cs_n_in <= 1'b0;
		ram_dq_out_in <= 4'ha;
		ram_dq_oe_in <= 4'hf;
		wr(OFF_FIXED, 32'h7);
		settle();
		chk("ram out", 64'h29, 64'(pad_out_out[5:0]));
		chk("ram oe", 64'h3f, 64'(pad_oe_out[5:0]));
		ram_dq_oe_in <= 4'h0;
		ext_val[5:2] <= 4'h5;
		settle();
		chk("ram in", 64'h5, 64'(ram_dq_out));
		wr(OFF_FIXED, 32'(FIXED_RESET));
		{app_dbg_dio_in, app_dbg_dio_oe_in, proto_dbg_dio_in, proto_dbg_dio_oe_in} <= 4'hf;
		ext_val[7] <= 1'b1;
		ext_val[9] <= 1'b1;
		settle();
		chk("dbg", 64'hff, 64'({pad_out_out[8], pad_oe_out[8], pad_out_out[6], pad_oe_out[6],
			proto_dbg_clk_out, app_dbg_clk_out, proto_dbg_dio_out, app_dbg_dio_out}));
		summarize();
	end
endmodule : tb_port_pin_mux_gpio
